// ### logic/pio_port_io.v
// pio_port_io.v: general-purpose port i/o with pin multiplexer
// assumes a processor-side register port synchronous to clk and
// pin levels that are already synchronous to clk
//
// Functional notes
// R1 - every port register can be written and read as a byte or as one bit.
// R2 - a write stores into an output latch that drives the pins until the next write.
// R3 - a normal read returns pin levels, even for muxed pins, when in digital mode.
// R4 - read-modify-write accesses read the latch, not the pins, and write it back.
// R5 - each pin driver is selectable open-drain or push-pull by its config register.
// R6 - the mux selection never changes the driver mode; only config does.
// R7 - mux registers exist for ports zero, one and two and route peripheral signals; here only the port-zero register routes any signal.
// R8 - each pin is digital or analog by a per-port mode register, digital by default.
// R9 - a mode bit of one selects digital input and all mode bits reset to one.
// R10 - after reset drivers are open-drain and latches hold ones.
// R11 - an open-drain pin whose latch is one is not driven.
// R12 - setting the timer zero route bit connects bit four of port zero to timer zero.
// R13 - software keeps timer-input pins open-drain with latch one to avoid contention.
// R14 - the block builds with three or four ports.
// R15 - an analog-mode pin has its digital input off and reads a fixed value.
`timescale 1ns/1ps
`include "pio_defines.vh"

module pio_port_io #(
   parameter NPORTS = `PIO_NPORTS
) (
   // clock and reset
   input wire clk,
   input wire rstn,
   // register port
   input wire reg_wr,
   input wire reg_rd,
   input wire reg_rmw,
   input wire reg_bit_op,
   input wire [2:0] reg_kind,
   input wire [`PIO_SEL_W-1:0] reg_port,
   input wire [`PIO_BIT_W-1:0] reg_bit,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   // pins, four ports packed, port zero in the low byte
   input wire [31:0] pin_in,
   output wire [31:0] pin_out,
   output wire [31:0] pin_oe_n,
   // peripheral inputs routed from port zero
   output reg timer_zero_input,
   output reg timer_one_input,
   output reg timer_two_input,
   output reg timer_two_external_trigger
);

   localparam PW = `PIO_PORT_W;

   // reset release through two flops
   reg rst_s1_q;
   reg rst_s2_q;
   wire rst_n;

   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   assign rst_n = rst_s2_q;

   // register storage, indexed by port
   reg [PW-1:0] latch_q [0:3];
   reg [PW-1:0] drive_q [0:3];
   reg [PW-1:0] kind_q [0:3];
   reg [PW-1:0] mux_q [0:2];
   wire [PW-1:0] level [0:3];

   // merge a byte or a single bit into an old value
   function [7:0] merge;
      input [7:0] old;
      input bit_op;
      input [2:0] idx;
      input [7:0] wdata;
      reg [7:0] m;
      begin
         m = 8'h00;
         m[idx] = 1'b1;
         if (bit_op)
            merge = (old & ~m) | ({8{wdata[0]}} & m); // R1
         else
            merge = wdata; // R1
      end
   endfunction

   // select a byte or one bit of a value
   function [7:0] pick;
      input [7:0] v;
      input bit_op;
      input [2:0] idx;
      begin
         if (bit_op)
            pick = {7'h00, v[idx]};
         else
            pick = v;
      end
   endfunction

   // true when a port index exists in this build
   function present;
      input [1:0] p;
      begin
         present = ({30'h0, p} < NPORTS); // R14
      end
   endfunction

   wire hit = present(reg_port);
   wire mux_hit = hit && (reg_port != 2'h3); // R7

   // port register writes
   genvar p;
   generate
      for (p = 0; p < 4; p = p + 1)
      begin : g_port
         wire sel = (reg_port == p) && reg_wr && hit;
         always @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               latch_q[p] <= `PIO_LATCH_RST; // R10
               drive_q[p] <= `PIO_DRIVE_RST; // R10
               kind_q[p] <= `PIO_KIND_RST; // R8 R9
            end
            else if (sel)
            begin
               // rmw and plain writes both land in the latch
               if (reg_kind == `PIO_REG_LATCH)
                  latch_q[p] <= merge(latch_q[p], reg_bit_op, reg_bit,
                                      reg_wdata); // R2 R4
               if (reg_kind == `PIO_REG_DRIVE)
                  drive_q[p] <= merge(drive_q[p], reg_bit_op, reg_bit,
                                      reg_wdata); // R5
               if (reg_kind == `PIO_REG_KIND)
                  kind_q[p] <= merge(kind_q[p], reg_bit_op, reg_bit,
                                     reg_wdata); // R8
            end
         end
         if (p < 3)
         begin : g_mux
            always @(posedge clk or negedge rst_n)
            begin
               if (!rst_n)
                  mux_q[p] <= `PIO_MUX_RST;
               else if (sel && reg_kind == `PIO_REG_MUX)
                  mux_q[p] <= merge(mux_q[p], reg_bit_op, reg_bit,
                                    reg_wdata); // R7
            end
         end
         // absent ports are never driven
         if (p < NPORTS)
         begin : g_cell
            // driver mode only from config, never from mux
            pio_pin_cell #(
               .W(PW)
            ) u_cell (
               .latch(latch_q[p]),
               .push_pull(drive_q[p]), // R6
               .digital(kind_q[p]),
               .pin_in(pin_in[p*PW +: PW]),
               .pin_out(pin_out[p*PW +: PW]),
               .pin_oe_n(pin_oe_n[p*PW +: PW]),
               .level(level[p])
            );
         end
         else
         begin : g_none
            assign pin_out[p*PW +: PW] = {PW{1'b1}};
            assign pin_oe_n[p*PW +: PW] = {PW{1'b1}};
            assign level[p] = {PW{1'b0}};
         end
      end
   endgenerate

   // read data, registered
   reg [7:0] rd_d;
   always @*
   begin
      rd_d = 8'h00;
      if (hit)
      begin
         case (reg_kind)
            `PIO_REG_LATCH:
               // rmw reads the latch, normal reads the pins
               if (reg_rmw)
                  rd_d = pick(latch_q[reg_port], reg_bit_op,
                              reg_bit); // R4
               else
                  rd_d = pick(level[reg_port], reg_bit_op,
                              reg_bit); // R3
            `PIO_REG_DRIVE:
               rd_d = pick(drive_q[reg_port], reg_bit_op, reg_bit);
            `PIO_REG_KIND:
               rd_d = pick(kind_q[reg_port], reg_bit_op, reg_bit);
            `PIO_REG_MUX:
               if (mux_hit)
                  rd_d = pick(mux_q[reg_port], reg_bit_op, reg_bit);
            default:
               rd_d = 8'h00;
         endcase
      end
   end

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= 8'h00;
      else if (reg_rd)
         reg_rdata <= rd_d;
   end

   // peripheral routing from port zero; idle high when not routed
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         timer_zero_input <= 1'b1;
         timer_one_input <= 1'b1;
         timer_two_input <= 1'b1;
         timer_two_external_trigger <= 1'b1;
      end
      else
      begin
         timer_zero_input <= mux_q[0][`PIO_MUX_T0] ?
            level[0][`PIO_PIN_T0] : 1'b1; // R12
         timer_one_input <= mux_q[0][`PIO_MUX_T1] ?
            level[0][`PIO_PIN_T1] : 1'b1; // R7
         timer_two_input <= mux_q[0][`PIO_MUX_T2] ?
            level[0][`PIO_PIN_T2] : 1'b1; // R7
         timer_two_external_trigger <= mux_q[0][`PIO_MUX_TIMER_TWO_EXTERNAL_TRIGGER] ?
            level[0][`PIO_PIN_TIMER_TWO_EXTERNAL_TRIGGER] : 1'b1; // R7
      end
   end

endmodule

// ### shared/pio_defines.vh
// pio_defines.vh: constants for the port i/o block
// assumes inclusion by bare name from design files
`ifndef PIO_DEFINES_VH
`define PIO_DEFINES_VH

// port geometry
`define PIO_PORT_W 8
`define PIO_NPORTS 4
`define PIO_SEL_W 2
`define PIO_BIT_W 3

// register select codes on the special function port
`define PIO_REG_LATCH 3'h0
`define PIO_REG_DRIVE 3'h1
`define PIO_REG_KIND 3'h2
`define PIO_REG_MUX 3'h3

// access kinds
`define PIO_OP_BYTE 1'b0
`define PIO_OP_BIT 1'b1

// reset values
`define PIO_LATCH_RST 8'hff
`define PIO_DRIVE_RST 8'h00
`define PIO_KIND_RST 8'hff
`define PIO_MUX_RST 8'h00

// value read back from a pin in analog mode
`define PIO_ANALOG_READ 1'b0

// port-zero mux bits and timer pins
`define PIO_MUX_T0 0
`define PIO_MUX_T1 1
`define PIO_MUX_T2 2
`define PIO_MUX_TIMER_TWO_EXTERNAL_TRIGGER 3
`define PIO_PIN_T0 4
`define PIO_PIN_T1 5
`define PIO_PIN_T2 6
`define PIO_PIN_TIMER_TWO_EXTERNAL_TRIGGER 7

`endif

// ### logic/pio_pin_cell.v
// pio_pin_cell.v: one port of eight pin drivers and input gates
// assumes pin levels already synchronous to the system clock
`timescale 1ns/1ps
`include "pio_defines.vh"

module pio_pin_cell #(
   parameter W = 8
) (
   // configuration and data
   input wire [W-1:0] latch,
   input wire [W-1:0] push_pull,
   input wire [W-1:0] digital,
   // pad
   input wire [W-1:0] pin_in,
   output wire [W-1:0] pin_out,
   output wire [W-1:0] pin_oe_n,
   // gated input level
   output wire [W-1:0] level
);

   genvar i;
   generate
      for (i = 0; i < W; i = i + 1)
      begin : g_pin
         // low is always driven; high only when push-pull
         assign pin_out[i] = latch[i];
         assign pin_oe_n[i] = latch[i] & ~push_pull[i]; // R5 R11
         // analog pins read a fixed value
         assign level[i] = digital[i] ? pin_in[i]
                                      : `PIO_ANALOG_READ; // R3 R15
      end
   endgenerate

endmodule

// ### sim/pio_pin_model.sv
// pio_pin_model.sv: external circuitry on the port pins
// assumes pull-ups on every pin and a bench that sets ext_en/ext_val
`timescale 1ns/1ps

module pio_pin_model (
   // from the block
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe_n,
   // forced levels from the bench
   input wire logic [31:0] ext_en,
   input wire logic [31:0] ext_val,
   // resolved levels
   output logic [31:0] pin_in
);
   // driven pins win, released pins float to the pull-up unless forced
   assign pin_in = (~pin_oe_n & pin_out) |
      (pin_oe_n & ((ext_en & ext_val) | ~ext_en));
endmodule

// ### sim/pio_port_io_sva.sv
// pio_port_io_sva.sv: port-level checker for the port i/o block
// assumes the block's register port and pins as seen at its boundary
`timescale 1ns/1ps

module pio_port_io_chk #(
   parameter NPORTS = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic reg_rmw,
   input wire logic reg_bit_op,
   input wire logic [2:0] reg_kind,
   input wire logic [1:0] reg_port,
   input wire logic [2:0] reg_bit,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // pins and timer route
   input wire logic [31:0] pin_in,
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe_n,
   input wire logic timer_zero_input
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // latch write to a present port, and reset release
   sequence s_wr0;
      reg_wr && reg_kind == 3'h0 && reg_port < NPORTS;
   endsequence
   sequence s_rel;
      $rose(rstn);
   endsequence

   property p_byte_wr;
      s_wr0 ##0 !reg_bit_op |=>
         pin_out[8*$past(reg_port)+:8] == $past(reg_wdata);
   endproperty
   a_byte_wr: assert property (p_byte_wr)
      else $error("byte write not on pins");
   property p_bit_wr;
      s_wr0 ##0 reg_bit_op |=> pin_out[{$past(reg_port), $past(reg_bit)}]
         == |($past(reg_wdata) & 8'h01);
   endproperty
   a_bit_wr: assert property (p_bit_wr)
      else $error("bit write not on pin");
   property p_hold;
      !(reg_wr && reg_kind == 3'h0) |=> $stable(pin_out);
   endproperty
   a_hold: assert property (p_hold)
      else $error("pins changed without write");
   property p_rst;
      s_rel |-> (pin_out == 32'hffffffff && pin_oe_n == 32'hffffffff)[*3];
   endproperty
   a_rst: assert property (p_rst)
      else $error("reset state wrong");
   property p_low_drv;
      (~pin_out & pin_oe_n) == 32'h00000000;
   endproperty
   a_low_drv: assert property (p_low_drv)
      else $error("low latch not driven");
   property p_rmw;
      reg_rd && reg_rmw && reg_kind == 3'h0 && !reg_bit_op &&
         reg_port < NPORTS |=> {24'h000000, reg_rdata} ==
         (($past(pin_out) >> {$past(reg_port), 3'h0}) & 32'h000000ff);
   endproperty
   a_rmw: assert property (p_rmw)
      else $error("rmw read not latch");
   property p_rd_hold;
      !reg_rd |=> $stable(reg_rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data moved");
   property p_t0;
      !timer_zero_input |-> (~$past(pin_in) & 32'h00000010) != 32'h0;
   endproperty
   a_t0: assert property (p_t0)
      else $error("timer zero low without pin");
endmodule

bind pio_port_io pio_port_io_chk #(.NPORTS(NPORTS)) u_chk (.*);

// ### sim/tb.sv
// tb.sv: self-checking bench for the port i/o block
// assumes the pin model resolves the pads; inputs move on falling edges
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
   num_errors++; $display("MISMATCH %0t got %h exp %h", $time, a, b); \
   end end

module tb;
   logic clk = 1'h0;
   logic rstn = 1'h0;
   logic reg_wr = 1'h0, reg_rd = 1'h0, reg_rmw = 1'h0, reg_bit_op = 1'h0;
   logic [2:0] reg_kind = 3'h0, reg_bit = 3'h0;
   logic [1:0] reg_port = 2'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic [31:0] ext_en = 32'h0, ext_val = 32'h0;
   wire [7:0] reg_rdata;
   wire [31:0] pin_in, pin_out, pin_oe_n;
   wire t0, t1, t2, t2x;
   int num_errors = 0, check_count = 0;

   // 50 MHz system clock
   always #10 clk = ~clk;

   pio_port_io #(.NPORTS(4)) u_pio_port_io (.clk(clk), .rstn(rstn),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rmw(reg_rmw),
      .reg_bit_op(reg_bit_op), .reg_kind(reg_kind), .reg_port(reg_port),
      .reg_bit(reg_bit), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .timer_zero_input(t0), .timer_one_input(t1), .timer_two_input(t2),
      .timer_two_external_trigger(t2x));
   pio_pin_model u_pio_pin_model (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

   // three-port build on the same register strobes, pads pulled high
   if (1)
   begin : g_three
      wire [7:0] rdata3;
      wire [31:0] pin_out3, oe3;
      pio_port_io #(.NPORTS(3)) u_pio_port_io (.clk(clk), .rstn(rstn),
         .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rmw(reg_rmw),
         .reg_bit_op(reg_bit_op), .reg_kind(reg_kind), .reg_port(reg_port),
         .reg_bit(reg_bit), .reg_wdata(reg_wdata), .reg_rdata(rdata3),
         .pin_in(32'hffffffff), .pin_out(pin_out3), .pin_oe_n(oe3),
         .timer_zero_input(), .timer_one_input(), .timer_two_input(),
         .timer_two_external_trigger());
   end

   // one register access: w=1 write, else read (m marks rmw)
   task acc(input w, input m, input [2:0] k, input [1:0] p, input b,
      input [2:0] i, input [7:0] d);
      begin
         @(negedge clk);
         {reg_wr, reg_rd, reg_rmw} = {w, !w, m};
         {reg_kind, reg_port, reg_bit_op, reg_bit, reg_wdata} = {k, p, b, i, d};
         @(negedge clk);
         {reg_wr, reg_rd, reg_rmw} = 3'h0;
      end
   endtask

   task t_reset;
      for (int p = 0; p < 4; p++)
      begin
         acc(1'h0, 1'h1, 3'h0, p[1:0], 1'h0, 3'h0, 8'h00);
         `CHK(reg_rdata, 8'hff)
         acc(1'h0, 1'h0, 3'h1, p[1:0], 1'h0, 3'h0, 8'h00);
         `CHK(reg_rdata, 8'h00)
         acc(1'h0, 1'h0, 3'h2, p[1:0], 1'h0, 3'h0, 8'h00);
         `CHK(reg_rdata, 8'hff)
      end
   endtask

   task t_latch;
      begin
         acc(1'h1, 1'h0, 3'h0, 2'h1, 1'h0, 3'h0, 8'h5a);
         `CHK(pin_out[15:8], 8'h5a)
         `CHK(pin_oe_n[15:8], 8'h5a)
         ext_en = 32'h00000200;
         acc(1'h0, 1'h0, 3'h0, 2'h1, 1'h0, 3'h0, 8'h00);
         `CHK(reg_rdata, 8'h58)
         acc(1'h0, 1'h1, 3'h0, 2'h1, 1'h0, 3'h0, 8'h00);
         `CHK(reg_rdata, 8'h5a)
         ext_en = 32'h0;
      end
   endtask

   task t_drive;
      begin
         acc(1'h1, 1'h0, 3'h1, 2'h1, 1'h0, 3'h0, 8'h0f);
         `CHK(pin_oe_n[15:8], 8'h50)
         acc(1'h1, 1'h0, 3'h3, 2'h1, 1'h0, 3'h0, 8'hff);
         `CHK(pin_oe_n[15:8], 8'h50)
         acc(1'h0, 1'h0, 3'h3, 2'h1, 1'h0, 3'h0, 8'h00);
         `CHK(reg_rdata, 8'hff)
         // muxed pin six released and pulled low outside
         ext_en = 32'h00004000;
         acc(1'h0, 1'h0, 3'h0, 2'h1, 1'h0, 3'h0, 8'h00);
         `CHK(reg_rdata, 8'h1a)
         ext_en = 32'h0;
      end
   endtask

   // port three exists only in the four-port build
   task t_three;
      begin
         acc(1'h1, 1'h0, 3'h0, 2'h3, 1'h0, 3'h0, 8'h3c);
         `CHK(pin_out[31:24], 8'h3c)
         `CHK(g_three.pin_out3[31:24], 8'hff)
         `CHK(g_three.oe3[31:24], 8'hff)
         acc(1'h0, 1'h1, 3'h0, 2'h3, 1'h0, 3'h0, 8'h00);
         `CHK(reg_rdata, 8'h3c)
         `CHK(g_three.rdata3, 8'h00)
         acc(1'h0, 1'h1, 3'h0, 2'h2, 1'h0, 3'h0, 8'h00);
         `CHK(g_three.rdata3, 8'hff)
      end
   endtask

   task t_bit_analog;
      begin
         acc(1'h1, 1'h0, 3'h0, 2'h0, 1'h1, 3'h3, 8'h00);
         `CHK(pin_out[7:0], 8'hf7)
         acc(1'h0, 1'h0, 3'h0, 2'h0, 1'h1, 3'h4, 8'h00);
         `CHK(reg_rdata, 8'h01)
         acc(1'h1, 1'h0, 3'h2, 2'h0, 1'h0, 3'h0, 8'hf0);
         acc(1'h0, 1'h0, 3'h0, 2'h0, 1'h0, 3'h0, 8'h00);
         `CHK(reg_rdata, 8'hf0)
      end
   endtask

   task t_timer;
      begin
         // pin four left open-drain with latch high, then pulled low
         ext_en = 32'h000000f0;
         repeat (2) @(negedge clk);
         `CHK(t0, 1'h1)
         `CHK(({t1, t2, t2x}), 3'h7)
         acc(1'h1, 1'h0, 3'h3, 2'h0, 1'h0, 3'h0, 8'h01);
         repeat (2) @(negedge clk);
         `CHK(t0, 1'h0)
         `CHK(({t1, t2, t2x}), 3'h7)
         acc(1'h1, 1'h0, 3'h3, 2'h0, 1'h0, 3'h0, 8'h0f);
         repeat (2) @(negedge clk);
         `CHK(({t0, t1, t2, t2x}), 4'h0)
         acc(1'h1, 1'h0, 3'h3, 2'h3, 1'h0, 3'h0, 8'hff);
         acc(1'h0, 1'h0, 3'h3, 2'h3, 1'h0, 3'h0, 8'h00);
         `CHK(reg_rdata, 8'h00)
         rstn = 1'h0;
         @(negedge clk);
         `CHK(pin_out, 32'hffffffff)
         `CHK(pin_oe_n, 32'hffffffff)
         rstn = 1'h1;
         repeat (3) @(negedge clk);
      end
   endtask

   task give_verdict;
      begin
         $display("errors %0d checks %0d", num_errors, check_count);
         if (num_errors == 0 && check_count > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask

   // reset, then each scenario in turn
   initial
   begin
      repeat (16) @(negedge clk);
      rstn = 1'h1;
      repeat (3) @(negedge clk);
      t_reset();
      t_latch();
      t_drive();
      t_bit_analog();
      t_three();
      t_timer();
      give_verdict();
   end
endmodule
